/* synth_cfg_consts.svh */
`ifndef SYNTH_CFG_CONSTS_SVH
`define SYNTH_CFG_CONSTS_SVH
// word indexes; byte address is index times four
`define IDX_RSV_A 8'h36
`define IDX_RSV_B 8'h37
`define IDX_RSV_C 8'h38
`define IDX_RSV_D 8'h39
`define IDX_ALIGN_CFG 8'h3a
`define IDX_LOCK_SEL 8'h3b
`define IDX_LOCK_DLY 8'h3c
// reset values
`define RST_RSV_A 16'h0000
`define RST_RSV_B 16'h0000
`define RST_RSV_C 16'h0000
`define RST_RSV_D 16'h0000
`define RST_ALIGN_CFG 16'h8001
`define RST_LOCK_SEL 16'h0001
`define RST_LOCK_DLY 16'h03e8
// field positions
`define POS_DISREGARD 15
`define POS_HYST 14
`define POS_BIAS_HI 13
`define POS_BIAS_LO 12
`define POS_FMT_HI 11
`define POS_FMT_LO 9
`define POS_KIND 0
// soft reset control word of our own, bit 1 resets the slice
`define IDX_SOFT_RST 8'h00
`define POS_SOFT_RST 1
// status word of our own
`define IDX_STATUS 8'h3d
// phase-detector quarter period prescale, in system clocks
`define QTR_PD_CYCLES 16'd4
`endif

/* synth_cfg_pkg.sv */
package synth_cfg_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [2:0] {
      LK_IDLE = 3'b001,
      LK_WAIT = 3'b010,
      LK_DONE = 3'b100
   } lock_state_t;
endpackage : synth_cfg_pkg

/* lock_if.sv */
`timescale 1ns/1ps
interface lock_if;
   logic start;
   logic tick;
   logic [15:0] delay;
   logic expired;
   modport ctrl (output start, output tick, output delay, input expired);
   modport timer (input start, input tick, input delay, output expired);
endinterface : lock_if

/* lock_delay_timer.sv */
`timescale 1ns/1ps
module lock_delay_timer
   import synth_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   lock_if.timer lk
);
   lock_state_t state_reg;
   lock_state_t state_next;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic expired_reg;

   // counting in quarter phase-detector periods after calibration ends
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         LK_IDLE: begin
            if (lk.start) begin
               state_next = LK_WAIT;
               count_next = lk.delay;
            end
         end
         LK_WAIT: begin
            if (!lk.start) begin
               state_next = LK_IDLE;
            end else if (count_reg == 16'h0000) begin
               state_next = LK_DONE;
            end else if (lk.tick) begin
               count_next = count_reg - 16'h0001;
            end
         end
         LK_DONE: begin
            if (!lk.start) begin
               state_next = LK_IDLE;
            end
         end
         default: begin
            state_next = LK_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg <= LK_IDLE;
         count_reg <= 16'h0000;
         expired_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         expired_reg <= (state_next == LK_DONE);
      end
   end

   assign lk.expired = expired_reg;

   property p_no_early_expiry;
      @(posedge clk) disable iff (!resetn)
         (state_reg == LK_WAIT && count_reg != 16'h0000) |=> !expired_reg;
   endproperty
   a_no_early_expiry: assert property (p_no_early_expiry)
      else $error("lock delay expired before count ended");
endmodule : lock_delay_timer

/* quarter_tick.sv */
`timescale 1ns/1ps
`include "synth_cfg_consts.svh"
module quarter_tick (
   input wire logic clk,
   input wire logic resetn,
   output logic tick
);
   logic [15:0] div_reg;

   // one-cycle enable every quarter of a phase-detector period
   always_ff @(posedge clk) begin
      if (!resetn) begin
         div_reg <= 16'h0000;
         tick <= 1'b0;
      end else begin
         tick <= (div_reg == `QTR_PD_CYCLES - 16'd1);
         div_reg <= (div_reg == `QTR_PD_CYCLES - 16'd1) ? 16'h0000 : div_reg + 16'h0001;
      end
   end
endmodule : quarter_tick

/* synth_cfg_regs.sv */
`timescale 1ns/1ps
`include "synth_cfg_consts.svh"
module synth_cfg_regs
   import synth_cfg_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic OSCILLATOR_CALIBRATION_DONE,
   input wire logic TUNE_VOLTAGE_IN_RANGE,
   input wire logic OSCILLATOR_PHASE_ALIGNMENT_ENABLE,
   input wire logic SYNC_PIN,
   input wire logic SYSTEM_REFERENCE_REQUEST_PIN,
   output logic SYNC_ACCEPTED,
   output logic SYSTEM_REFERENCE_REQUEST_ACCEPTED,
   output logic ALIGNMENT_RECEIVER_HYSTERESIS,
   output logic [1:0] DIFFERENTIAL_BIAS_SELECT,
   output logic SYNC_DIFFERENTIAL,
   output logic REQUEST_DIFFERENTIAL,
   output logic SYNC_FILTERED,
   output logic REQUEST_FILTERED,
   output logic LOCK_INDICATOR
);
   word_t rsv_a_reg;
   word_t rsv_b_reg;
   word_t rsv_c_reg;
   word_t rsv_d_reg;
   word_t align_reg;
   word_t lock_sel_reg;
   word_t lock_dly_reg;
   logic soft_rst_reg;
   logic [31:0] prdata_next;

   lock_if lk ();
   logic tick_w;

   // word index decode, used for both write and read paths
   function automatic logic [7:0] word_index(input logic [31:0] addr);
      word_index = addr[9:2];
   endfunction : word_index

   wire logic [7:0] idx = word_index(PADDR);
   wire logic aligned = (PADDR[1:0] == 2'b00) && (PADDR[31:10] == 22'h0);
   wire logic wr_stb = PSEL && PENABLE && PWRITE && aligned;
   wire logic mapped = aligned && (idx == `IDX_SOFT_RST || idx == `IDX_STATUS
      || (idx >= `IDX_RSV_A && idx <= `IDX_LOCK_DLY));
   wire logic do_reset = !RESETN || soft_rst_reg;
   wire word_t wdat = PWDATA[15:0];

   // decoded alignment fields
   wire logic [2:0] fmt = align_reg[`POS_FMT_HI:`POS_FMT_LO];
   wire logic fmt_filt = fmt[2] && (fmt[1:0] != 2'b00);
   wire logic disregard = align_reg[`POS_DISREGARD] && !OSCILLATOR_PHASE_ALIGNMENT_ENABLE;
   wire logic kind = lock_sel_reg[`POS_KIND];
   wire logic cal_lock = lk.expired;
   wire logic lock_w = kind ? (cal_lock && TUNE_VOLTAGE_IN_RANGE) : cal_lock;

   // configuration words; soft reset reloads defaults so reserved words A to C need no rewrite
   always_ff @(posedge CLK) begin
      if (do_reset) begin
         rsv_a_reg <= `RST_RSV_A;
         rsv_b_reg <= `RST_RSV_B;
         rsv_c_reg <= `RST_RSV_C;
         rsv_d_reg <= `RST_RSV_D;
         align_reg <= `RST_ALIGN_CFG;
         lock_sel_reg <= `RST_LOCK_SEL;
         lock_dly_reg <= `RST_LOCK_DLY;
      end else if (wr_stb) begin
         if (idx == `IDX_RSV_A) rsv_a_reg <= wdat;
         if (idx == `IDX_RSV_B) rsv_b_reg <= wdat;
         if (idx == `IDX_RSV_C) rsv_c_reg <= wdat;
         if (idx == `IDX_RSV_D) rsv_d_reg <= wdat;
         if (idx == `IDX_ALIGN_CFG) align_reg <= wdat;
         if (idx == `IDX_LOCK_SEL) lock_sel_reg <= wdat;
         if (idx == `IDX_LOCK_DLY) lock_dly_reg <= wdat;
      end
   end

   // soft reset is a self-clearing pulse so the slice comes back after one cycle
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         soft_rst_reg <= 1'b0;
      end else begin
         soft_rst_reg <= wr_stb && idx == `IDX_SOFT_RST && PWDATA[`POS_SOFT_RST];
      end
   end

   // read mux; status word shows calibration lock and final lock
   always_comb begin
      prdata_next = 32'h0;
      case (idx)
         `IDX_RSV_A: prdata_next = {16'h0, rsv_a_reg};
         `IDX_RSV_B: prdata_next = {16'h0, rsv_b_reg};
         `IDX_RSV_C: prdata_next = {16'h0, rsv_c_reg};
         `IDX_RSV_D: prdata_next = {16'h0, rsv_d_reg};
         `IDX_ALIGN_CFG: prdata_next = {16'h0, align_reg};
         `IDX_LOCK_SEL: prdata_next = {16'h0, lock_sel_reg};
         `IDX_LOCK_DLY: prdata_next = {16'h0, lock_dly_reg};
         `IDX_STATUS: prdata_next = {30'h0, LOCK_INDICATOR, cal_lock};
         default: prdata_next = 32'h0;
      endcase
   end

   // apb answer: no wait state, ready in the access cycle after setup
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && !PREADY;
         PSLVERR <= PSEL && !PREADY && !mapped;
         PRDATA <= (PSEL && !PWRITE && mapped) ? prdata_next : 32'h0;
      end
   end

   // receiver configuration and gated alignment inputs
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         SYNC_ACCEPTED <= 1'b0;
         SYSTEM_REFERENCE_REQUEST_ACCEPTED <= 1'b0;
         ALIGNMENT_RECEIVER_HYSTERESIS <= 1'b0;
         DIFFERENTIAL_BIAS_SELECT <= 2'b00;
         SYNC_DIFFERENTIAL <= 1'b0;
         REQUEST_DIFFERENTIAL <= 1'b0;
         SYNC_FILTERED <= 1'b0;
         REQUEST_FILTERED <= 1'b0;
         LOCK_INDICATOR <= 1'b0;
      end else begin
         SYNC_ACCEPTED <= SYNC_PIN && !disregard;
         SYSTEM_REFERENCE_REQUEST_ACCEPTED <= SYSTEM_REFERENCE_REQUEST_PIN && !disregard;
         ALIGNMENT_RECEIVER_HYSTERESIS <= align_reg[`POS_HYST];
         // code 3 is invalid; its value is passed on unchanged
         DIFFERENTIAL_BIAS_SELECT <= align_reg[`POS_BIAS_HI:`POS_BIAS_LO];
         SYNC_DIFFERENTIAL <= fmt[0] && (fmt[1:0] != 2'b00);
         REQUEST_DIFFERENTIAL <= fmt[1];
         SYNC_FILTERED <= fmt_filt && fmt[0];
         REQUEST_FILTERED <= fmt_filt && fmt[1];
         LOCK_INDICATOR <= lock_w;
      end
   end

   assign lk.start = OSCILLATOR_CALIBRATION_DONE && !do_reset;
   assign lk.tick = tick_w;
   assign lk.delay = lock_dly_reg;

   quarter_tick u_tick (
      .clk(CLK),
      .resetn(RESETN),
      .tick(tick_w)
   );

   lock_delay_timer u_timer (
      .clk(CLK),
      .resetn(RESETN),
      .lk(lk.timer)
   );

   property p_disregard;
      @(posedge CLK) disable iff (!RESETN)
         (align_reg[15] && !OSCILLATOR_PHASE_ALIGNMENT_ENABLE) |=> !SYNC_ACCEPTED;
   endproperty
   a_disregard: assert property (p_disregard)
      else $error("sync accepted while disregarded");

   property p_hyst;
      @(posedge CLK) disable iff (!RESETN)
         1'b1 |=> ALIGNMENT_RECEIVER_HYSTERESIS == $past(align_reg[`POS_HYST]);
   endproperty
   a_hyst: assert property (p_hyst)
      else $error("hysteresis not following bit 14");

   property p_bias;
      @(posedge CLK) disable iff (!RESETN)
         1'b1 |=> DIFFERENTIAL_BIAS_SELECT == $past(align_reg[`POS_BIAS_HI:`POS_BIAS_LO]);
   endproperty
   a_bias: assert property (p_bias)
      else $error("bias select mismatch");

   property p_cmos;
      @(posedge CLK) disable iff (!RESETN)
         (fmt == 3'h0 || fmt == 3'h4) |=> !SYNC_DIFFERENTIAL && !REQUEST_DIFFERENTIAL;
   endproperty
   a_cmos: assert property (p_cmos)
      else $error("format 0 or 4 not single-ended");

   property p_filt;
      @(posedge CLK) disable iff (!RESETN)
         (align_reg[11:9] == 3'd7) |=> SYNC_FILTERED && REQUEST_FILTERED && SYNC_DIFFERENTIAL;
   endproperty
   a_filt: assert property (p_filt)
      else $error("format 7 not filtered differential");

   property p_lock_cal;
      @(posedge CLK) disable iff (!RESETN) $rose(LOCK_INDICATOR) |-> $past(lk.expired);
   endproperty
   a_lock_cal: assert property (p_lock_cal)
      else $error("lock rose without expired delay");

   property p_lock_vt;
      @(posedge CLK) disable iff (!RESETN)
         (lock_sel_reg[0] && !TUNE_VOLTAGE_IN_RANGE) |=> !LOCK_INDICATOR;
   endproperty
   a_lock_vt: assert property (p_lock_vt)
      else $error("lock high with tuning voltage out of range");

   property p_readback;
      @(posedge CLK) disable iff (!RESETN)
         (wr_stb && idx == `IDX_LOCK_DLY && !soft_rst_reg) |=>
            lock_dly_reg == $past(PWDATA[15:0]);
   endproperty
   a_readback: assert property (p_readback)
      else $error("written word not stored");

   property p_soft;
      @(posedge CLK) disable iff (!RESETN)
         soft_rst_reg |=> rsv_a_reg == `RST_RSV_A && align_reg == `RST_ALIGN_CFG;
   endproperty
   a_soft: assert property (p_soft)
      else $error("soft reset did not restore defaults");

   // reserved words B and C and both lock words come back too, so the host may skip reloading them
   property p_soft_rest;
      @(posedge CLK) disable iff (!RESETN)
         soft_rst_reg |=> rsv_b_reg == `RST_RSV_B && rsv_c_reg == `RST_RSV_C
            && lock_sel_reg == `RST_LOCK_SEL && lock_dly_reg == `RST_LOCK_DLY;
   endproperty
   a_soft_rest: assert property (p_soft_rest)
      else $error("soft reset left a word unrestored");

   // pins count as disregarded only while phase alignment is off
   sequence s_disregarded;
      align_reg[`POS_DISREGARD] && !OSCILLATOR_PHASE_ALIGNMENT_ENABLE;
   endsequence

   property p_disregard_req;
      @(posedge CLK) disable iff (!RESETN)
         s_disregarded |=> !SYSTEM_REFERENCE_REQUEST_ACCEPTED;
   endproperty
   a_disregard_req: assert property (p_disregard_req)
      else $error("request accepted while disregarded");

   // when not disregarded each pin must reach its output one cycle later
   property p_pass;
      @(posedge CLK) disable iff (!RESETN)
         !disregard |=> SYNC_ACCEPTED == $past(SYNC_PIN)
            && SYSTEM_REFERENCE_REQUEST_ACCEPTED == $past(SYSTEM_REFERENCE_REQUEST_PIN);
   endproperty
   a_pass: assert property (p_pass)
      else $error("alignment pin lost while not disregarded");

   property p_sync_only;
      @(posedge CLK) disable iff (!RESETN)
         (fmt == 3'h1 || fmt == 3'h5) |=> SYNC_DIFFERENTIAL && !REQUEST_DIFFERENTIAL;
   endproperty
   a_sync_only: assert property (p_sync_only)
      else $error("format 1 or 5 not sync-only differential");

   property p_req_only;
      @(posedge CLK) disable iff (!RESETN)
         (fmt == 3'h2 || fmt == 3'h6) |=> !SYNC_DIFFERENTIAL && REQUEST_DIFFERENTIAL;
   endproperty
   a_req_only: assert property (p_req_only)
      else $error("format 2 or 6 not request-only differential");

   property p_unfiltered;
      @(posedge CLK) disable iff (!RESETN)
         (fmt <= 3'h4) |=> !SYNC_FILTERED && !REQUEST_FILTERED;
   endproperty
   a_unfiltered: assert property (p_unfiltered)
      else $error("filter on for format 0 to 4");

   // apb setup cycle, after which ready comes in the first access cycle
   sequence s_setup;
      PSEL && !PENABLE && !PREADY;
   endsequence

   property p_one_wait;
      @(posedge CLK) disable iff (!RESETN)
         s_setup |=> PREADY;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("no ready in the access cycle");

   property p_ready_pulse;
      @(posedge CLK) disable iff (!RESETN)
         PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held longer than one cycle");

   // a write to the alignment word must land, unless a soft reset wins
   sequence s_align_write;
      wr_stb && idx == `IDX_ALIGN_CFG && !soft_rst_reg;
   endsequence

   property p_write_lands;
      @(posedge CLK) disable iff (!RESETN)
         s_align_write |=> align_reg == $past(PWDATA[15:0]);
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("alignment word write not stored");

   // lock falls two cycles after calibration done drops: timer, then output stage
   property p_lock_drop;
      @(posedge CLK) disable iff (!RESETN)
         !OSCILLATOR_CALIBRATION_DONE |-> ##2 !LOCK_INDICATOR;
   endproperty
   a_lock_drop: assert property (p_lock_drop)
      else $error("lock held without calibration done");
endmodule : synth_cfg_regs

/* synth_input_pin_lockdetect_cfg_test.sv */
`timescale 1ns/1ps
`include "synth_cfg_consts.svh"
module synth_input_pin_lockdetect_cfg_test
   import synth_cfg_pkg::*;
;
   logic clk, resetn, psel, penable, pwrite;
   logic [31:0] paddr, pwdata, prdata;
   logic pready, pslverr;
   logic cal_done, tune_ok, phase_en, sync_pin, req_pin;
   logic sync_acc, req_acc, hyst, sync_diff, req_diff, sync_filt, req_filt, lock;
   logic [1:0] bias;
   int n_errors = 0;
   int checked = 0;
   // slice words and their defaults, delay word last
   logic [7:0] idx_tab [7] = '{`IDX_RSV_A, `IDX_RSV_B, `IDX_RSV_C, `IDX_RSV_D,
      `IDX_ALIGN_CFG, `IDX_LOCK_SEL, `IDX_LOCK_DLY};
   word_t rst_tab [7] = '{`RST_RSV_A, `RST_RSV_B, `RST_RSV_C, `RST_RSV_D,
      `RST_ALIGN_CFG, `RST_LOCK_SEL, `RST_LOCK_DLY};

   synth_cfg_regs uut (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .OSCILLATOR_CALIBRATION_DONE(cal_done),
      .TUNE_VOLTAGE_IN_RANGE(tune_ok), .OSCILLATOR_PHASE_ALIGNMENT_ENABLE(phase_en),
      .SYNC_PIN(sync_pin), .SYSTEM_REFERENCE_REQUEST_PIN(req_pin),
      .SYNC_ACCEPTED(sync_acc), .SYSTEM_REFERENCE_REQUEST_ACCEPTED(req_acc),
      .ALIGNMENT_RECEIVER_HYSTERESIS(hyst), .DIFFERENTIAL_BIAS_SELECT(bias),
      .SYNC_DIFFERENTIAL(sync_diff), .REQUEST_DIFFERENTIAL(req_diff),
      .SYNC_FILTERED(sync_filt), .REQUEST_FILTERED(req_filt), .LOCK_INDICATOR(lock));

   // 200 mhz system clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one apb transfer, entered just after a rising edge; an idle edge follows the
   // release so the next call never drives psel twice in one time step
   task automatic apb(input logic wr, input logic [7:0] idx, input word_t wd,
      output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= {16'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // waits as long as it takes; only the watchdog ends a hung transfer
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      chk("pready wait", 32'h1, n);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [7:0] idx, input word_t d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
      chk("write pslverr", 32'h0, {31'h0, e});
   endtask : wr

   task automatic rdc(input string what, input logic [7:0] idx, input word_t exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 16'h0, r, e);
      chk(what, {16'h0, exp}, r);
      chk("read pslverr", 32'h0, {31'h0, e});
   endtask : rdc

   task automatic t_defaults();
      for (int i = 0; i < 7; i++)
         rdc("default", idx_tab[i], rst_tab[i]);
   endtask : t_defaults

   // patterns read back, then an unmapped word is refused
   task automatic t_readback();
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 7; i++)
         wr(idx_tab[i], 16'ha5c0 + 16'(i));
      for (int i = 0; i < 7; i++)
         rdc("readback", idx_tab[i], 16'ha5c0 + 16'(i));
      apb(1'b1, 8'h50, 16'hffff, r, e);
      chk("unmapped write err", 32'h1, {31'h0, e});
      apb(1'b0, 8'h50, 16'h0, r, e);
      chk("unmapped read data", 32'h0, r);
      chk("unmapped read err", 32'h1, {31'h0, e});
   endtask : t_readback

   // soft reset must bring back the defaults without rewriting
   task automatic t_soft_reset();
      wr(`IDX_SOFT_RST, 16'h0002);
      repeat (2) @(posedge clk);
      t_defaults();
   endtask : t_soft_reset

   // values the host must load
   task automatic t_host_values();
      wr(`IDX_RSV_A, 16'h0000);
      wr(`IDX_RSV_B, 16'h0000);
      wr(`IDX_RSV_C, 16'h0000);
      wr(`IDX_RSV_D, 16'h0020);
      wr(`IDX_ALIGN_CFG, 16'h8001);
      wr(`IDX_LOCK_SEL, 16'h0001);
      rdc("reserved d", `IDX_RSV_D, 16'h0020);
      rdc("align cfg", `IDX_ALIGN_CFG, 16'h8001);
   endtask : t_host_values

   // every format code, with hysteresis and bias codes 0..2 swept alongside
   task automatic t_formats();
      logic [2:0] f;
      logic [1:0] b;
      for (int i = 0; i < 8; i++) begin
         f = 3'(i);
         b = 2'(i % 3);
         wr(`IDX_ALIGN_CFG, {1'b1, f[0], b, f, 9'h001});
         repeat (2) @(posedge clk);
         chk("hysteresis", {31'h0, f[0]}, {31'h0, hyst});
         chk("bias", {30'h0, b}, {30'h0, bias});
         // odd codes make sync differential, codes 2,3,6,7 the request input
         chk("sync diff", {31'h0, f[0]}, {31'h0, sync_diff});
         chk("req diff", {31'h0, f[1]}, {31'h0, req_diff});
         chk("sync filt", {31'h0, f[2] & f[0]}, {31'h0, sync_filt});
         chk("req filt", {31'h0, f[2] & f[1]}, {31'h0, req_filt});
      end
      wr(`IDX_ALIGN_CFG, 16'h8001);
   endtask : t_formats

   task automatic t_disregard();
      sync_pin <= 1'b1;
      req_pin <= 1'b1;
      phase_en <= 1'b0;
      repeat (3) @(posedge clk);
      chk("sync ignored", 32'h0, {31'h0, sync_acc});
      chk("req ignored", 32'h0, {31'h0, req_acc});
      phase_en <= 1'b1;
      repeat (3) @(posedge clk);
      chk("sync aligned", 32'h1, {31'h0, sync_acc});
      chk("req aligned", 32'h1, {31'h0, req_acc});
      wr(`IDX_ALIGN_CFG, 16'h0001);
      sync_pin <= 1'b0;
      repeat (3) @(posedge clk);
      chk("sync open", 32'h0, {31'h0, sync_acc});
      chk("req open", 32'h1, {31'h0, req_acc});
      req_pin <= 1'b0;
      wr(`IDX_ALIGN_CFG, 16'h8001);
      phase_en <= 1'b0;
   endtask : t_disregard

   task automatic wait_lock(input int lim);
      int n;
      n = 0;
      while (lock !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_lock

   // kind 0: three quarter periods of four clocks, tune voltage ignored
   task automatic t_lock_cal();
      wr(`IDX_LOCK_DLY, 16'd3);
      wr(`IDX_LOCK_SEL, 16'h0000);
      tune_ok <= 1'b0;
      cal_done <= 1'b1;
      repeat (12) @(posedge clk);
      chk("lock early", 32'h0, {31'h0, lock});
      wait_lock(8);
      chk("lock after delay", 32'h1, {31'h0, lock});
      cal_done <= 1'b0;
      repeat (3) @(posedge clk);
      chk("lock dropped", 32'h0, {31'h0, lock});
      rdc("status low", `IDX_STATUS, 16'h0000);
   endtask : t_lock_cal

   // kind 1: tune voltage out of range holds lock low
   task automatic t_lock_tune();
      wr(`IDX_LOCK_SEL, 16'h0001);
      cal_done <= 1'b1;
      repeat (30) @(posedge clk);
      chk("lock no tune", 32'h0, {31'h0, lock});
      tune_ok <= 1'b1;
      wait_lock(4);
      chk("lock with tune", 32'h1, {31'h0, lock});
      rdc("status locked", `IDX_STATUS, 16'h0003);
      cal_done <= 1'b0;
   endtask : t_lock_tune

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      n_errors++;
      test_done();
   end

   initial begin
      {resetn, psel, penable, pwrite, cal_done, tune_ok, phase_en, sync_pin, req_pin} = '0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_defaults();
      t_readback();
      t_soft_reset();
      t_host_values();
      t_formats();
      t_disregard();
      t_lock_cal();
      t_lock_tune();
      test_done();
   end
endmodule : synth_input_pin_lockdetect_cfg_test
